/* sfd_pkg.sv */
// Purpose: shared constants and carriers for the divider chain
// Assumes: one clock, divider inputs already synchronous
// Notes: counts are held at CNT_W bits for every divider channel
`default_nettype none
package sfd_pkg;
	// divider widths
	localparam int REF_W = 15;
	localparam int CNT_W = 17;
	localparam int FRAC_W = 4;
	localparam int RF_WORD_W = 19;
	// rf word field positions (bit 1 of the word is index 0)
	localparam int C_LSB = 8;
	localparam int B_LSB = 6;
	localparam int A_LSB = 4;
	localparam int NUM_LSB = 0;
	localparam int RANGE_BIT = 7;
	// prescaler base moduli and swallow weights
	localparam logic [4:0] P_LOW = 5'h08;
	localparam logic [4:0] P_HIGH = 5'h10;
	localparam logic [2:0] B_WEIGHT = 3'h4;
	localparam logic [3:0] IF_P = 4'h8;
	// fractional moduli
	localparam logic [4:0] MOD_15 = 5'h0F;
	localparam logic [4:0] MOD_16 = 5'h10;
	// smallest usable ratio of any counter
	localparam logic [CNT_W-1:0] MIN_RATIO = 17'h00003;
	// reset values
	localparam logic [RF_WORD_W-1:0] RF_WORD_RST = 19'h00000;
	localparam logic [FRAC_W-1:0] ACC_RST = 4'h0;
	// channel indices of the divider array
	localparam int CH_IF_R = 0;
	localparam int CH_RF_R = 1;
	localparam int CH_IF_N = 2;
	localparam int CH_RF_N = 3;
	localparam int NCH = 4;

	// rf feedback divider word
	typedef struct packed {
		logic [10:0] coarse;
		logic [1:0] mid;
		logic [1:0] low;
		logic [3:0] num;
	} sfd_rf_word_t;

	// if feedback divider word
	typedef struct packed {
		logic [11:0] coarse;
		logic [2:0] swallow;
	} sfd_if_word_t;

	// per-divider pulse bundle toward the phase detectors
	typedef struct packed {
		logic rf_feedback;
		logic if_feedback;
		logic rf_reference;
		logic if_reference;
	} sfd_pd_t;
endpackage
`default_nettype wire

/* sfd_dividers.sv */
// Purpose: reference and feedback divider chain of a dual synthesizer
// Assumes: all inputs synchronous to clk_in; detector and overflow outputs are one-cycle pulses
// Notes: each divider counts rising edges of its sampled input
//
// Contract
// R01: path select picks separate or common reference paths for both dividers.
// R02: common path: if reference input clocks both reference dividers.
// R03: separate path: each reference input clocks only its own divider.
// R04: reference dividers are 15-bit, ratio 3 to 32767.
// R05: rf feedback counts rf divider input, if feedback counts if input.
// R06: rf feedback divider runs fractional or pure integer.
// R07: rf word is 19 bits: 15 integer, 4 fractional.
// R08: rf integer part: 2-bit low, 2-bit mid, 11-bit coarse counts.
// R09: lower range: ratios 40..16383 fractional, 24 upward integer.
// R10: upper range: ratios 80..32767 fractional, 48 upward integer.
// R11: fractional modulus selectable fifteen or sixteen.
// R12: if feedback: 3-bit swallow, 12-bit coarse, ratio 56..32767.
// R13: if feedback divider is integer only.
// R14: word bit 8 low selects lower range, high selects upper.
// R15: word fields: coarse 19..9, mid 8..7, low 6..5, numerator 4..1.
// R16: programmer always loads coarse of at least three.
// R17: programmer checks small ratios before loading.
// R18: locked output equals comparison rate times integer plus fraction.
// R19: reference output feeds detector reference, feedback output the compared side.
// R20: 4-bit accumulator driven by numerator, modulus chosen separately.
// R21: each overflow swallows one extra input cycle that period.
// R22: rf ratio is base times coarse plus four mid plus low.
// R23: accumulator adds once per comparison cycle, wraps, flags overflow.
`default_nettype none
module sfd_dividers
	import sfd_pkg::*;
#(
	parameter int REF_BITS = REF_W
)(
	// clock and reset
	input  wire logic                 clk_in,
	input  wire logic                 resetn_in,
	// reference and divider inputs
	input  wire logic                 if_reference_input_in,
	input  wire logic                 rf_reference_input_in,
	input  wire logic                 rf_divider_input_in,
	input  wire logic                 if_divider_input_in,
	// configuration
	input  wire logic                 reference_path_select_in,
	input  wire logic [REF_BITS-1:0]  if_ref_ratio_in,
	input  wire logic [REF_BITS-1:0]  rf_ref_ratio_in,
	input  wire sfd_if_word_t         if_fb_word_in,
	input  wire logic                 rf_frac_mode_in,
	input  wire logic                 rf_frac_mod16_in,
	// rf feedback divider word load
	input  wire logic [RF_WORD_W-1:0] rf_feedback_divider_word_in,
	input  wire logic                 rf_word_load_in,
	// toward the phase detectors
	output var  sfd_pd_t              pd_pulses_out,
	// state visible outside
	output logic [RF_WORD_W-1:0]      rf_word_out,
	output logic [FRAC_W-1:0]         frac_acc_out,
	output logic                      frac_overflow_out
);

	// widths that the counters cannot serve are refused
	if (REF_BITS < 2 || REF_BITS > CNT_W - 1)
	begin : g_chk
		$error("sfd_dividers: REF_BITS out of range");
	end

	// stored rf word and fractional state
	logic [RF_WORD_W-1:0] rf_word_q;
	logic [FRAC_W-1:0]    acc_q;
	logic [FRAC_W-1:0]    acc_d;
	logic                 swallow_q;
	logic                 swallow_d;
	logic                 ovf_q;
	logic                 ovf_d;

	// input history for edge detection
	logic [3:0] in_prev_q;
	logic [3:0] in_now;
	logic [3:0] in_edge;

	// per-channel counter array
	logic [CNT_W-1:0] cnt_q [NCH];
	logic [CNT_W-1:0] ratio [NCH];
	logic [NCH-1:0]   ch_step;
	logic [NCH-1:0]   ch_wrap;
	logic [NCH-1:0]   pulse_q;

	// decoded rf word
	sfd_rf_word_t rf_w;
	logic         upper_range;
	logic [4:0]   p_base;
	logic [CNT_W-1:0] rf_int;
	logic [CNT_W-1:0] if_int;
	logic [4:0]   frac_mod;
	logic [5:0]   acc_sum;
	logic         acc_wrap;
	logic         cmp_tick;

	// inputs are synchronous, so a one-flop history gives the edges
	assign in_now = {rf_divider_input_in, if_divider_input_in,
		rf_reference_input_in, if_reference_input_in};
	assign in_edge = in_now & ~in_prev_q;

	// reference path routing
	assign ch_step[CH_IF_R] = in_edge[0]; // R03
	assign ch_step[CH_RF_R] = reference_path_select_in ? in_edge[0] // R02
		: in_edge[1]; // R01
	// feedback dividers count their own signal inputs
	assign ch_step[CH_IF_N] = in_edge[2]; // R05
	assign ch_step[CH_RF_N] = in_edge[3]; // R05

	// rf word fields and prescaler range
	assign rf_w = sfd_rf_word_t'(rf_word_q); // R15
	assign upper_range = rf_word_q[RANGE_BIT]; // R14
	assign p_base = upper_range ? P_HIGH : P_LOW; // R09
	// integer ratio: base times coarse plus weighted swallows
	assign rf_int = CNT_W'(p_base * rf_w.coarse) // R22
		+ CNT_W'(B_WEIGHT * rf_w.mid) // R08
		+ CNT_W'(rf_w.low); // R10
	// if divider: fixed 8 base with a 3-bit swallow, no fraction
	assign if_int = CNT_W'(IF_P * if_fb_word_in.coarse) // R12
		+ CNT_W'(if_fb_word_in.swallow); // R13

	// ratios below the floor are raised to it so no counter stalls
	assign ratio[CH_IF_R] = clamp(CNT_W'(if_ref_ratio_in)); // R04
	assign ratio[CH_RF_R] = clamp(CNT_W'(rf_ref_ratio_in)); // R04
	assign ratio[CH_IF_N] = clamp(if_int);
	// one extra input cycle whenever the accumulator wrapped
	assign ratio[CH_RF_N] = clamp(rf_int + CNT_W'(swallow_q)); // R21

	// floor every ratio at the smallest the counter can serve
	function automatic logic [CNT_W-1:0] clamp(input logic [CNT_W-1:0] r);
		clamp = (r < MIN_RATIO) ? MIN_RATIO : r;
	endfunction

	// fractional accumulator arithmetic
	assign frac_mod = rf_frac_mod16_in ? MOD_16 : MOD_15; // R11
	assign acc_sum = 6'(acc_q) + 6'(rf_w.num); // R20
	assign acc_wrap = acc_sum >= 6'(frac_mod); // R23
	// one step per comparison cycle, taken at the rf reference output
	assign cmp_tick = ch_wrap[CH_RF_R];

	// next accumulator state; integer mode keeps it idle
	always_comb
	begin
		acc_d = acc_q;
		ovf_d = 1'b0;
		swallow_d = swallow_q;
		if (!rf_frac_mode_in)
		begin
			acc_d = ACC_RST; // R06
			swallow_d = 1'b0;
		end
		else if (cmp_tick)
		begin
			acc_d = acc_wrap ? FRAC_W'(acc_sum - 6'(frac_mod)) // R23
				: acc_sum[FRAC_W-1:0];
			ovf_d = acc_wrap;
			// swallow applies to the feedback period now starting
			swallow_d = acc_wrap; // R21
		end
	end

	// per-channel edge counters
	for (genvar i = 0; i < NCH; i++)
	begin : g_ch
		assign ch_wrap[i] = ch_step[i] && (cnt_q[i] >= ratio[i] - 1'b1);

		// count edges and restart at the programmed ratio
		always_ff @(posedge clk_in or negedge resetn_in)
		begin
			if (!resetn_in)
			begin
				cnt_q[i] <= '0;
				pulse_q[i] <= 1'b0;
			end
			else
			begin
				pulse_q[i] <= ch_wrap[i];
				if (ch_wrap[i])
					cnt_q[i] <= '0;
				else if (ch_step[i])
					cnt_q[i] <= cnt_q[i] + 1'b1;
			end
		end
	end

	// word register and input history
	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			rf_word_q <= RF_WORD_RST;
			in_prev_q <= 4'h0;
		end
		else
		begin
			in_prev_q <= in_now;
			if (rf_word_load_in)
				rf_word_q <= rf_feedback_divider_word_in; // R07
		end
	end

	// fractional state
	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			acc_q <= ACC_RST;
			swallow_q <= 1'b0;
			ovf_q <= 1'b0;
		end
		else
		begin
			acc_q <= acc_d;
			swallow_q <= swallow_d;
			ovf_q <= ovf_d;
		end
	end

	// detector outputs: reference side and feedback side
	always_comb
	begin
		pd_pulses_out.if_reference = pulse_q[CH_IF_R]; // R19
		pd_pulses_out.rf_reference = pulse_q[CH_RF_R]; // R19
		pd_pulses_out.if_feedback = pulse_q[CH_IF_N]; // R19
		pd_pulses_out.rf_feedback = pulse_q[CH_RF_N]; // R18
	end

	// status straight from flops
	assign rf_word_out = rf_word_q;
	assign frac_acc_out = acc_q;
	assign frac_overflow_out = ovf_q;

endmodule
`default_nettype wire

/* sfd_src.sv */
// Purpose: oscillator and vco line source
// Assumes: lines toggle each clock, so they run at half the clock rate
// Notes: a stopped line rests low, like an open input
`default_nettype none
module sfd_src (
	// clock and enables
	input wire logic       clk_in,
	input wire logic [3:0] run_in,
	// if ref, rf ref, rf vco, if vco
	output var logic [3:0] line_out = 4'h0
);
	timeunit 1ns;
	timeprecision 1ns;
	// falling edge, so the divider samples settled levels
	always @(negedge clk_in)
		line_out <= run_in & ~line_out;
endmodule
`default_nettype wire

/* sfd_chk.sv */
// Purpose: port assertions for sfd_dividers
// Assumes: one clock, async low reset
// Notes: bound below
`default_nettype none
module sfd_chk
	import sfd_pkg::*;
(
	// clock, reset, inputs
	input wire logic                 clk_in,
	input wire logic                 resetn_in,
	input wire logic                 if_reference_input_in,
	input wire logic                 rf_reference_input_in,
	input wire logic                 rf_divider_input_in,
	input wire logic                 reference_path_select_in,
	input wire logic                 rf_frac_mode_in,
	input wire logic                 rf_frac_mod16_in,
	input wire logic [RF_WORD_W-1:0] rf_feedback_divider_word_in,
	input wire logic                 rf_word_load_in,
	// outputs
	input wire sfd_pd_t              pd_pulses_out,
	input wire logic [RF_WORD_W-1:0] rf_word_out,
	input wire logic [FRAC_W-1:0]    frac_acc_out,
	input wire logic                 frac_overflow_out
);
	// 5-bit so sums do not wrap
	wire logic [4:0] mod_w = rf_frac_mod16_in ? MOD_16 : MOD_15;
	wire logic [4:0] num_w = {1'b0, rf_word_out[3:0]};
	default clocking @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	a_word_load: assert property (rf_word_load_in |=>
		rf_word_out == $past(rf_feedback_divider_word_in)) else $error("word lost");
	a_word_hold: assert property (!rf_word_load_in |=> $stable(rf_word_out))
		else $error("word moved");
	a_int_acc: assert property (!rf_frac_mode_in |=> frac_acc_out == ACC_RST)
		else $error("acc in integer mode");
	a_ovf_wrap: assert property (frac_overflow_out && $past(rf_frac_mode_in) |->
		{1'b0, frac_acc_out} == {1'b0, $past(frac_acc_out)} + $past(num_w) - $past(mod_w))
		else $error("bad wrap");
	a_acc_add: assert property ($past(rf_frac_mode_in) && !frac_overflow_out
		&& $changed(frac_acc_out) |-> {1'b0, frac_acc_out} ==
		{1'b0, $past(frac_acc_out)} + $past(num_w)) else $error("bad add");
	a_ovf_single: assert property (frac_overflow_out |=> !frac_overflow_out)
		else $error("long overflow");
	a_ref_split: assert property ((!reference_path_select_in
		&& !rf_reference_input_in)[*4] |=> !pd_pulses_out.rf_reference) else $error("split");
	a_ref_common: assert property ((reference_path_select_in
		&& !if_reference_input_in)[*4] |=> !pd_pulses_out.rf_reference) else $error("common");
	a_fb_source: assert property (!rf_divider_input_in[*4]
		|=> !pd_pulses_out.rf_feedback) else $error("fb source");
	c_overflow: cover property (frac_overflow_out);
	c_common: cover property (reference_path_select_in && pd_pulses_out.rf_reference);
	c_upper: cover property (pd_pulses_out.rf_feedback && rf_word_out[7]);
endmodule
bind sfd_dividers sfd_chk i_sfd_chk (.clk_in(clk_in), .resetn_in(resetn_in),
	.if_reference_input_in(if_reference_input_in),
	.rf_reference_input_in(rf_reference_input_in), .rf_divider_input_in(rf_divider_input_in),
	.reference_path_select_in(reference_path_select_in), .rf_frac_mode_in(rf_frac_mode_in),
	.rf_frac_mod16_in(rf_frac_mod16_in), .rf_word_load_in(rf_word_load_in),
	.rf_feedback_divider_word_in(rf_feedback_divider_word_in), .rf_word_out(rf_word_out),
	.pd_pulses_out(pd_pulses_out), .frac_acc_out(frac_acc_out),
	.frac_overflow_out(frac_overflow_out));
`default_nettype wire

/* tb.sv */
// Purpose: bench for sfd_dividers
// Assumes: lines toggle each clock, so spans are twice the ratio
// Notes: pd bits: 0 if ref, 1 rf ref, 2 if fb, 3 rf fb
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import sfd_pkg::*;
	logic         clk = 0, rst_n = 0, sel = 0, fmode = 0, m16 = 0, load = 0;
	logic [3:0]   run = 4'h0, line, acc;
	logic [14:0]  ifr = 15'h0003, rfr = 15'h0003;
	logic [18:0]  word = 19'h00000, wq;
	logic         ovf;
	sfd_if_word_t ifw = 15'h0038;
	sfd_pd_t      pd;
	int           bad_count = 0, total_checks = 0;
	sfd_src i_sfd_src (.clk_in(clk), .run_in(run), .line_out(line));
	sfd_dividers i_sfd_dividers (.clk_in(clk), .resetn_in(rst_n),
		.if_reference_input_in(line[0]), .rf_reference_input_in(line[1]),
		.rf_divider_input_in(line[2]), .if_divider_input_in(line[3]),
		.reference_path_select_in(sel), .if_ref_ratio_in(ifr), .rf_ref_ratio_in(rfr),
		.if_fb_word_in(ifw), .rf_frac_mode_in(fmode), .rf_frac_mod16_in(m16),
		.rf_feedback_divider_word_in(word), .rf_word_load_in(load), .pd_pulses_out(pd),
		.rf_word_out(wq), .frac_acc_out(acc), .frac_overflow_out(ovf));
	always #4 clk = !clk;
	task automatic print_verdict();
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("Error %0t: %0d, want %0d", $time, got, exp);
		end
	endtask
	// clocks between two pulses of one divider; a stall ends the run
	task automatic span(input int b, input int exp);
		int n;
		n = 0;
		while (pd[b] !== 1'b1 && n < 40000)
		begin
			@(negedge clk);
			n++;
		end
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (pd[b] !== 1'b1 && n < 40000);
		check(n, exp);
		if (n == 40000)
			print_verdict();
	endtask
	// count pulses over 100 clocks, stale ones let out first
	task automatic quiet(input int b);
		int n;
		n = 0;
		repeat (8) @(negedge clk);
		repeat (100)
		begin
			@(negedge clk);
			n += (pd[b] !== 1'b0);
		end
		check(n, 0);
	endtask
	task automatic put(input logic [18:0] w);
		word = w;
		load = 1;
		@(negedge clk);
		load = 0;
		@(negedge clk);
		check(wq, w);
	endtask
	task automatic t_ref();
		run = 4'h1;
		span(0, 6);
		ifr = 15'h0064;
		span(0, 200);
		quiet(1);
		sel = 1;
		rfr = 15'h0005;
		span(1, 10);
		run = 4'h2;
		quiet(1);
		sel = 0;
		span(1, 10);
		quiet(0);
	endtask
	task automatic t_fb();
		// every coarse is at least three and no ratio sits below the legal floor
		logic [18:0] w [4] = '{19'h00500, 19'h00560, 19'h00590, 19'h7FF70};
		int e [4] = '{80, 92, 178, 32766};
		run = 4'hC;
		span(2, 112);
		ifw = 15'h003D;
		span(2, 122);
		for (int i = 0; i < 4; i++)
		begin
			put(w[i]);
			span(3, e[i]);
		end
	endtask
	// window starts mid-period, so it holds exactly k reference wraps
	task automatic t_frac();
		logic [3:0] u [4] = '{4'h8, 4'h8, 4'h1, 4'hF};
		int k [4] = '{16, 15, 16, 15};
		int x [4] = '{8, 8, 1, 15};
		int n;
		run = 4'h2;
		rfr = 15'h0003;
		for (int i = 0; i < 4; i++)
		begin
			fmode = 0;
			m16 = !i[0];
			put({15'h0500, u[i]});
			span(1, 6);
			repeat (3) @(negedge clk);
			fmode = 1;
			n = 0;
			repeat (k[i] * 6)
			begin
				@(negedge clk);
				n += (ovf !== 1'b0);
			end
			check(n, x[i]);
			check(acc, 0);
		end
		fmode = 0;
		// fifteen of fifteen wraps every tick, so each feedback period swallows one
		put(19'h0050F);
		run = 4'h6;
		fmode = 1;
		span(3, 82);
		fmode = 0;
	endtask
	initial
	begin
		repeat (16) @(negedge clk);
		rst_n = 1;
		@(negedge clk);
		t_ref();
		t_fb();
		t_frac();
		print_verdict();
	end
endmodule
`default_nettype wire
